// [src/sbsp_sram.sv]
// Purpose: synchronous burst sram with no turnaround wait states
// Assumes: all pins synchronous to i_mclk, driven by a same-clock controller
// Notes:   reset clears pipeline control only, never the array
// How it works
// - every pin captured on the rising clock except oe_n; oe_n and sleep_req gate the drive directly
// - clock gate high freezes all internal state
// - load low starts read, write or deselect
// - load high steps counter, keeps burst operation
// - two-bit burst counter wraps after four
// - counter seeded from two lowest address bits
// - order input picks interleaved or linear stepping
// - write low starts self-timed array write
// - only enabled byte lanes are written
// - reads and writes mix back to back
// - array is 256K words of 36 bits
// - three selects all asserted or deselect
// - shared data wire, memory drives reads only
`include "sbsp_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module sbsp_sram (
  input  wire logic i_mclk,
  input  wire logic i_rst,
  sbsp_if.mem       bus
);

  // next burst address low bits for a given step
  function automatic logic [1:0] sbsp_lsb(
    input logic [1:0] seed,
    input logic [1:0] step,
    input logic       ilv
  );
    // interleaved flips bits, linear adds with wrap
    sbsp_lsb = ilv ? (seed ^ step) : 2'(seed + step);
  endfunction

  // the array itself, one word per location
  sbsp_pkg::sbsp_word_t mem [0:`SBSP_DEPTH-1];

  // burst state held between loads
  sbsp_pkg::sbsp_op_e burst_op_r;  // operation of current burst
  logic [15:0]        base_r;      // upper address bits of burst
  logic [1:0]         seed_r;      // loaded low address bits
  logic [1:0]         step_r;      // burst counter

  // first stage: cycle as captured
  sbsp_pkg::sbsp_op_e a_op_r;
  logic [17:0]        a_addr_r;
  logic [3:0]         a_lane_r;
  // second stage: cycle one edge later
  sbsp_pkg::sbsp_op_e b_op_r;
  logic [17:0]        b_addr_r;
  logic [3:0]         b_lane_r;
  // third stage: write slot; its data is taken off the wire at the next edge
  sbsp_pkg::sbsp_op_e c_op_r;
  logic [17:0]        c_addr_r;
  logic [3:0]         c_lane_r;
  // output register and its drive flag
  sbsp_pkg::sbsp_word_t dout_r;
  logic                 drv_r;

  // a gated edge must leave everything as it was
  wire run = ~bus.clk_gate_n;

  // all three selects must agree, sleep masks them
  wire sel_ok = ~bus.sel_first_n & bus.sel_second
              & ~bus.sel_third_n & ~bus.sleep_req;

  // load low takes a fresh address
  wire load = ~bus.burst_step_or_load;

  // operation picked by a loading cycle
  wire sbsp_pkg::sbsp_op_e load_op =
    !sel_ok  ? sbsp_pkg::SBSP_OP_DESEL :
    bus.wr_n ? sbsp_pkg::SBSP_OP_READ :
               sbsp_pkg::SBSP_OP_WRITE;

  // stepping keeps the burst type; sleep still blocks it
  wire sbsp_pkg::sbsp_op_e step_op =
    bus.sleep_req ? sbsp_pkg::SBSP_OP_DESEL : burst_op_r;

  // counter value for this stepping cycle
  wire [1:0] step_nxt = 2'(step_r + 2'h1);

  // address of this cycle, burst bits from the counter
  wire [1:0] lsb_step = sbsp_lsb(seed_r, step_nxt, bus.order_sel);
  wire [17:0] cyc_addr = load ? bus.addr : {base_r, lsb_step};
  wire sbsp_pkg::sbsp_op_e cyc_op = load ? load_op : step_op;

  // word currently held at the read address
  wire sbsp_pkg::sbsp_word_t old_word = mem[b_addr_r];

  // word currently held at the write address
  wire sbsp_pkg::sbsp_word_t wr_old = mem[c_addr_r];

  // write data from the shared wire
  wire sbsp_pkg::sbsp_word_t wr_data = {bus.lane_check_io, bus.lane_io};

  // merge enabled lanes over the stored word
  sbsp_pkg::sbsp_word_t merged;
  always_comb begin
    merged = wr_old;
    for (int i = 0; i < `SBSP_LANES; i++) begin
      if (!c_lane_r[i]) begin
        // data byte plus its check bit
        merged[i*`SBSP_LANE_W +: `SBSP_LANE_W] =
          wr_data[i*`SBSP_LANE_W +: `SBSP_LANE_W];
        merged[`SBSP_CHK_POS + i] = wr_data[`SBSP_CHK_POS + i];
      end
    end
  end

  // a read one cycle behind a write to the same word meets that write on
  // the same edge; forward the merged word so the read sees the new data
  wire wr_hit = (c_op_r == sbsp_pkg::SBSP_OP_WRITE) && (c_addr_r == b_addr_r);
  wire sbsp_pkg::sbsp_word_t rd_word = wr_hit ? merged : old_word;

  // burst counter and burst type
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      burst_op_r <= sbsp_pkg::SBSP_OP_DESEL;
      base_r     <= 16'h0;
      seed_r     <= 2'h0;
      step_r     <= 2'h0;
    end else if (run) begin
      if (load) begin
        // fresh burst, counter seeded from address
        burst_op_r <= load_op;
        base_r     <= bus.addr[17:2];
        seed_r     <= bus.addr[1:0];
        step_r     <= 2'h0;
      end else begin
        // wraps on its own after four beats
        step_r <= step_nxt;
      end
    end
  end

  // capture stage, pins registered on the edge
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      a_op_r   <= sbsp_pkg::SBSP_OP_DESEL;
      a_addr_r <= 18'h0;
      a_lane_r <= 4'hf;
    end else if (run) begin
      a_op_r   <= cyc_op;
      a_addr_r <= cyc_addr;
      a_lane_r <= bus.lane_write_n;
    end
  end

  // second stage, one counted edge later
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      b_op_r   <= sbsp_pkg::SBSP_OP_DESEL;
      b_addr_r <= 18'h0;
      b_lane_r <= 4'hf;
    end else if (run) begin
      b_op_r   <= a_op_r;
      b_addr_r <= a_addr_r;
      b_lane_r <= a_lane_r;
    end
  end

  // third stage: a write waits here while its data stands on the wire,
  // in the same slot a read would use, so no turnaround cycle is needed
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      c_op_r   <= sbsp_pkg::SBSP_OP_DESEL;
      c_addr_r <= 18'h0;
      c_lane_r <= 4'hf;
    end else if (run) begin
      c_op_r   <= b_op_r;
      c_addr_r <= b_addr_r;
      c_lane_r <= b_lane_r;
    end
  end

  // array write, no reset: contents survive i_rst
  // the write finishes inside this edge, so no busy state is needed
  always_ff @(posedge i_mclk) begin
    if (!i_rst && run && c_op_r == sbsp_pkg::SBSP_OP_WRITE) begin
      mem[c_addr_r] <= merged;
    end
  end

  // read output register; read data and write data share one wire slot,
  // two counted edges after capture, so any mix runs back to back
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      dout_r <= 36'h0;
      drv_r  <= 1'b0;
    end else if (run) begin
      if (b_op_r == sbsp_pkg::SBSP_OP_READ) begin
        dout_r <= rd_word;
        drv_r  <= 1'b1;
      end else begin
        // write or deselect: release wire for controller
        drv_r <= 1'b0;
      end
    end
  end

  // drive only read data, only while enabled and awake
  assign bus.mem_q       = dout_r;
  assign bus.mem_drive_n = ~(drv_r & ~bus.oe_n & ~bus.sleep_req);

endmodule
`default_nettype wire

// [src/sbsp_defines.svh]
// Purpose: shared constants of the burst sram port
// Assumes: 36-bit organisation, four byte lanes with check bits
// Notes:   definitions only
`ifndef SBSP_DEFINES_SVH
`define SBSP_DEFINES_SVH

// array shape
`define SBSP_ADDR_W   18
`define SBSP_DEPTH    262144
`define SBSP_LANES    4
`define SBSP_LANE_W   8
`define SBSP_DATA_W   32
`define SBSP_WORD_W   36
// check bit of lane i sits at word bit SBSP_CHK_POS + i
`define SBSP_CHK_POS  32
// burst counter width
`define SBSP_BCNT_W   2
// clock edges from capture to read data or write data
`define SBSP_PIPE_LAT 2

`endif

// [src/sbsp_pkg.sv]
// Purpose: types used by the sram end
// Assumes: nothing
// Notes:   operation codes are gray along desel-read-write
package sbsp_pkg;

  // operation carried by a captured cycle
  typedef enum logic [1:0] {
    SBSP_OP_DESEL = 2'h0,
    SBSP_OP_READ  = 2'h1,
    SBSP_OP_WRITE = 2'h3
  } sbsp_op_e;

  // one memory word: check bits over data bytes
  typedef logic [35:0] sbsp_word_t;

endpackage

// [src/sbsp_if.sv]
// Purpose: pin bundle between memory and controller
// Assumes: both ends on the same clock
// Notes:   shared data wire is resolved here from the drive enables
`timescale 1ns/1ps
`default_nettype none
interface sbsp_if;
  logic        clk_gate_n;         // low: edge counts
  logic [17:0] addr;               // word address
  logic        sel_first_n;        // select, active low
  logic        sel_second;         // select, active high
  logic        sel_third_n;        // select, active low
  logic        burst_step_or_load; // low load, high step
  logic        wr_n;               // low write, high read
  logic [3:0]  lane_write_n;       // per lane write, active low
  logic        oe_n;               // output enable, active low
  logic        order_sel;          // high interleaved, low linear
  logic        sleep_req;          // sleep request, active high
  logic [35:0] mem_q;              // memory drive value
  logic        mem_drive_n;        // low while memory drives
  logic [35:0] ctl_q;              // controller drive value
  logic        ctl_drive_n;        // low while controller drives
  logic [31:0] lane_io;            // resolved data lanes
  logic [3:0]  lane_check_io;      // resolved check bits

  // an undriven wire reads as zero here
  assign lane_io = !mem_drive_n ? mem_q[31:0] :
                   !ctl_drive_n ? ctl_q[31:0] : 32'h0;
  assign lane_check_io = !mem_drive_n ? mem_q[35:32] :
                         !ctl_drive_n ? ctl_q[35:32] : 4'h0;

  modport mem (
    input  clk_gate_n, addr, sel_first_n, sel_second, sel_third_n,
    input  burst_step_or_load, wr_n, lane_write_n, oe_n, order_sel,
    input  sleep_req, lane_io, lane_check_io,
    output mem_q, mem_drive_n
  );
  modport ctl (
    output clk_gate_n, addr, sel_first_n, sel_second, sel_third_n,
    output burst_step_or_load, wr_n, lane_write_n, oe_n, order_sel,
    output sleep_req, ctl_q, ctl_drive_n,
    input  lane_io, lane_check_io
  );
endinterface
`default_nettype wire

// [src/sbsp_ctrl.sv]
// Purpose: controller end driving the burst sram pins
// Assumes: memory end shares i_mclk
// Notes:   one request per counted edge, reads return on o_rd_valid
`include "sbsp_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module sbsp_ctrl (
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  input  wire logic        i_req_valid,  // request present
  input  wire logic        i_req_wr,     // 1 write, 0 read
  input  wire logic        i_req_burst,  // 1 step burst, 0 load
  input  wire logic [17:0] i_req_addr,   // word address
  input  wire logic [3:0]  i_req_lane_n, // lane write enables, low
  input  wire logic [35:0] i_req_wdata,  // write word
  input  wire logic        i_stall,      // freeze the memory
  input  wire logic        i_order_sel,  // interleaved when high
  input  wire logic        i_sleep,      // sleep request
  output logic             o_req_ready,  // request taken this edge
  output logic             o_rd_valid,   // read word pulse
  output logic [35:0]      o_rd_data,    // read word
  sbsp_if.ctl              bus
);

  // pin registers
  logic        stall_r;
  logic [17:0] addr_r;
  logic        seln_r;
  logic        adv_r;
  logic        wrn_r;
  logic [3:0]  lane_r;
  logic        oen_r;
  logic        ord_r;
  logic        slp_r;
  // write data pipe and read tracking pipe
  logic        w1_r;
  logic [35:0] w1d_r;
  logic        w2_r;
  logic [35:0] w2d_r;
  logic        w3_r;
  logic [35:0] w3d_r;
  logic        wdrv_r;
  logic [35:0] wdat_r;
  logic [3:0]  rd_r;

  // current pins are consumed unless the gate is high
  wire adv_ok = ~stall_r;
  wire take   = adv_ok & i_req_valid;

  assign o_req_ready = adv_ok;

  // gate, order and sleep follow the user each edge
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      stall_r <= 1'b0;
      ord_r   <= 1'b0;
      slp_r   <= 1'b0;
      oen_r   <= 1'b1;
    end else begin
      stall_r <= i_stall;
      ord_r   <= i_order_sel;  // user keeps it static
      slp_r   <= i_sleep;
      oen_r   <= 1'b0;         // memory may drive its read slots
    end
  end

  // command pins, held while gated
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      addr_r <= 18'h0;
      seln_r <= 1'b1;
      adv_r  <= 1'b0;
      wrn_r  <= 1'b1;
      lane_r <= 4'hf;
    end else if (adv_ok) begin
      // idle slot is a loading deselect
      addr_r <= i_req_addr;
      seln_r <= ~take;
      adv_r  <= take & i_req_burst;
      wrn_r  <= ~(take & i_req_wr);
      lane_r <= (take & i_req_wr) ? i_req_lane_n : 4'hf;
    end
  end

  // write data two counted edges after the memory captures its address,
  // the same slot that read data uses
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      w1_r   <= 1'b0;
      w1d_r  <= 36'h0;
      w2_r   <= 1'b0;
      w2d_r  <= 36'h0;
      w3_r   <= 1'b0;
      w3d_r  <= 36'h0;
      wdrv_r <= 1'b0;
      wdat_r <= 36'h0;
    end else if (adv_ok) begin
      w1_r   <= take & i_req_wr;
      w1d_r  <= i_req_wdata;
      w2_r   <= w1_r;
      w2d_r  <= w1d_r;
      w3_r   <= w2_r;
      w3d_r  <= w2d_r;
      wdrv_r <= w3_r;
      wdat_r <= w3d_r;
    end
  end

  // read return, sampled one counted edge after memory loads it
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      rd_r       <= 4'h0;
      o_rd_valid <= 1'b0;
      o_rd_data  <= 36'h0;
    end else begin
      o_rd_valid <= adv_ok & rd_r[3];
      if (adv_ok) begin
        rd_r <= {rd_r[2:0], take & ~i_req_wr};
        if (rd_r[3]) begin
          o_rd_data <= {bus.lane_check_io, bus.lane_io};
        end
      end
    end
  end

  // pins; controller drives the wire only for write data
  assign bus.clk_gate_n         = stall_r;
  assign bus.addr               = addr_r;
  assign bus.sel_first_n        = seln_r;
  assign bus.sel_second         = ~seln_r;
  assign bus.sel_third_n        = seln_r;
  assign bus.burst_step_or_load = adv_r;
  assign bus.wr_n               = wrn_r;
  assign bus.lane_write_n       = lane_r;
  assign bus.oe_n               = oen_r;
  assign bus.order_sel          = ord_r;
  assign bus.sleep_req          = slp_r;
  assign bus.ctl_q              = wdat_r;
  assign bus.ctl_drive_n        = ~wdrv_r;

endmodule
`default_nettype wire

// [sim/sbsp_checker.sv]
// Purpose: pin-level checks between the burst sram end and the controller end
// Assumes: one clock, synchronous reset active high
// Notes:   latency checks track loads only, except drv_cause_a, which also accepts read steps; other step beats are left to the bench
`timescale 1ns/1ps
`default_nettype none
module sbsp_checker (
  input wire logic        i_mclk,
  input wire logic        i_rst,
  input wire logic        clk_gate_n,
  input wire logic        sel_first_n,
  input wire logic        sel_second,
  input wire logic        sel_third_n,
  input wire logic        burst_step_or_load,
  input wire logic        wr_n,
  input wire logic        oe_n,
  input wire logic        sleep_req,
  input wire logic [35:0] mem_q,
  input wire logic        mem_drive_n,
  input wire logic [35:0] ctl_q,
  input wire logic        ctl_drive_n
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  // counted edge with all three selects asserted and no sleep
  wire gate_on = !clk_gate_n;
  wire sel_ok  = gate_on && !sel_first_n && sel_second && !sel_third_n && !sleep_req;
  wire cap_rd  = sel_ok && !burst_step_or_load && wr_n;  // read load
  wire cap_wr  = sel_ok && !burst_step_or_load && !wr_n; // write load
  wire rd_any  = sel_ok && wr_n;                         // read load or step
  // deselect or write load: no read data owed for this slot
  wire cap_nr  = gate_on && (!sel_ok || (!burst_step_or_load && !wr_n));

  read_lat_a: assert property (cap_rd ##1 gate_on [*2] |=>
    (!mem_drive_n || oe_n || sleep_req)) else $error("read data missing on wire");
  rd_release_a: assert property (cap_nr ##1 gate_on [*2] |=> mem_drive_n)
    else $error("memory drives wire in a non-read slot");
  // write data uses the same slot as read data would
  wr_data_a: assert property (cap_wr ##1 gate_on [*2] |=> !ctl_drive_n)
    else $error("write data not presented in time");
  oe_gate_a: assert property (!mem_drive_n |-> !oe_n)
    else $error("memory drives wire with output enable off");
  sleep_off_a: assert property (sleep_req |-> mem_drive_n)
    else $error("memory drives wire during sleep");
  freeze_q_a: assert property (clk_gate_n |=> $stable(mem_q))
    else $error("read register moved on a gated edge");
  ctl_hold_a: assert property (clk_gate_n && !ctl_drive_n |=>
    $stable(ctl_q) && !ctl_drive_n) else $error("write data moved on a gated edge");
  drv_cause_a: assert property ($fell(mem_drive_n) && $past(gate_on)
    && $past(gate_on, 2) |-> $past(rd_any, 3)) else $error("drive without a read");
  // a read followed at once by a write must not clash on the wire
  one_drv_a: assert property (mem_drive_n || ctl_drive_n)
    else $error("memory and controller drive the wire together");

  // main traffic kinds reached
  rd_c: cover property (cap_rd);
  wr_c: cover property (cap_wr);
  step_c: cover property (rd_any && burst_step_or_load);
  stall_c: cover property (clk_gate_n ##1 gate_on);
endmodule
`default_nettype wire

// [sim/tb_top.sv]
// Purpose: self-checking bench joining the sram end and the controller end
// Assumes: controller returns each read word once on o_rd_valid, in order
// Notes:   rows carry write data, or for reads the word that must come back
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
  $display("FAIL %s exp %h got %h", nm, e, g); end end
module tb_top;
  typedef struct {bit wr; logic [17:0] a; logic [3:0] ln; logic [35:0] d;} sbsp_row_s;
  logic        i_mclk, i_rst, i_req_valid, i_req_wr, i_req_burst;
  logic        i_stall, i_order_sel, i_sleep, o_req_ready, o_rd_valid, taken;
  logic [17:0] i_req_addr;
  logic [3:0]  i_req_lane_n;
  logic [35:0] i_req_wdata, o_rd_data, exp_v;
  logic [35:0] exp_q [$];                  // read words still owed
  int          num_errors = 0, checks_done = 0, cyc = 0;
  // back to back: write then read at once, read then write at once
  sbsp_row_s   rows [8] = '{
    '{1, 18'h00010, 4'h0, 36'h9_1234_5678}, '{1, 18'h3ffff, 4'h0, 36'h6_cafe_f00d},
    '{0, 18'h00010, 4'h0, 36'h9_1234_5678}, '{1, 18'h00010, 4'ha, 36'hf_aaaa_5555},
    '{0, 18'h00010, 4'h0, 36'hd_12aa_5655}, '{0, 18'h3ffff, 4'h0, 36'h6_cafe_f00d},
    '{1, 18'h3ffff, 4'h5, 36'h9_1122_3344}, '{0, 18'h3ffff, 4'h0, 36'hc_11fe_330d}};

  sbsp_if bus();
  sbsp_sram sbsp_sram_inst (.i_mclk, .i_rst, .bus(bus));
  sbsp_ctrl sbsp_ctrl_inst (.i_mclk, .i_rst, .i_req_valid, .i_req_wr, .i_req_burst,
    .i_req_addr, .i_req_lane_n, .i_req_wdata, .i_stall, .i_order_sel, .i_sleep,
    .o_req_ready, .o_rd_valid, .o_rd_data, .bus(bus));
  sbsp_checker sbsp_checker_inst (.i_mclk, .i_rst, .clk_gate_n(bus.clk_gate_n),
    .sel_first_n(bus.sel_first_n), .sel_second(bus.sel_second),
    .sel_third_n(bus.sel_third_n), .burst_step_or_load(bus.burst_step_or_load),
    .wr_n(bus.wr_n), .oe_n(bus.oe_n), .sleep_req(bus.sleep_req), .mem_q(bus.mem_q),
    .mem_drive_n(bus.mem_drive_n), .ctl_q(bus.ctl_q), .ctl_drive_n(bus.ctl_drive_n));

  initial begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end

  // a request counts only on an edge where the gate let it in
  always @(posedge i_mclk) taken <= i_req_valid && o_req_ready;

  // returned words checked in order; a stray word meets an unknown
  always @(negedge i_mclk) begin
    cyc++;
    if (cyc > 2000) begin
      num_errors++;
      end_of_test();
    end
    if (o_rd_valid === 1'b1) begin
      exp_v = exp_q.size() ? exp_q.pop_front() : 36'hx;
      `CHK("rd_data", exp_v, o_rd_data)
    end
  end

  // present one request and hold it until an edge takes it
  task automatic req(bit wr, bit bt, logic [17:0] a, logic [3:0] ln, logic [35:0] d);
    int n = 0;
    {i_req_valid, i_req_wr, i_req_burst} = {1'b1, wr, bt};
    {i_req_addr, i_req_lane_n, i_req_wdata} = {a, ln, d};
    do begin @(negedge i_mclk); n++; end while (taken !== 1'b1 && n < 40);
    `CHK("taken", 1'b1, taken)
    if (!wr) exp_q.push_back(d);
  endtask

  task automatic idle(int k);
    i_req_valid = 1'b0;
    repeat (k) @(negedge i_mclk);
  endtask

  // wait, bounded, until every owed read word has come back
  task automatic drain();
    int n = 0;
    while (exp_q.size() != 0 && n < 30) begin @(negedge i_mclk); n++; end
    `CHK("drained", 0, exp_q.size())
  endtask

  // four beats from a seed; word d+k goes to the k-th address of the order
  task automatic burst(bit wr, logic [17:0] a, logic [35:0] d);
    logic [1:0] lo;
    for (int k = 0; k < 4; k++) begin
      lo = i_order_sel ? a[1:0] ^ k[1:0] : a[1:0] + k[1:0];
      req(wr, k != 0, {a[17:2], lo}, 4'h0, d + k);
    end
  endtask

  task automatic end_of_test();
    $display("checks_done %0d num_errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    logic [1:0]  kk;
    logic [35:0] base;
    {i_rst, i_req_valid, i_req_wr, i_req_burst, i_stall, i_order_sel, i_sleep} = 7'h40;
    {i_req_addr, i_req_lane_n, i_req_wdata} = 58'h0;
    repeat (3) @(negedge i_mclk);
    i_rst = 1'b0;
    foreach (rows[i]) req(rows[i].wr, 1'b0, rows[i].a, rows[i].ln, rows[i].d);
    idle(1);
    drain();
    // seed 1 tells linear (1,2,3,0) from interleaved (1,0,3,2)
    for (int m = 0; m < 2; m++) begin
      i_order_sel = m[0];
      base = 36'h3_0000_0a00 + 36'h10 * m;
      idle(2);
      burst(1'b1, 18'h00101, base);
      for (int j = 0; j < 4; j++) begin
        kk = m ? j[1:0] ^ 2'h1 : j[1:0] - 2'h1;
        req(1'b0, 1'b0, {16'h0040, j[1:0]}, 4'h0, base + kk);
      end
      // stall the memory in mid-burst; words must still come back whole
      fork
        begin
          repeat (2) @(negedge i_mclk);
          i_stall = 1'b1;
          repeat (3) @(negedge i_mclk);
          i_stall = 1'b0;
        end
      join_none
      burst(1'b0, 18'h00101, base);
      idle(1);
      drain();
    end
    // sleep, then a second reset: wire released, contents kept
    // a read while asleep is ignored: the wire stays released and reads 0
    i_sleep = 1'b1;
    idle(2);
    req(1'b0, 1'b0, 18'h00010, 4'h0, 36'h0);
    idle(3);
    `CHK("sleep_drive", 1'b1, bus.mem_drive_n)
    drain();
    i_sleep = 1'b0;
    i_rst = 1'b1;
    idle(2);
    `CHK("rst_rd_valid", 1'b0, o_rd_valid)
    `CHK("rst_ctl_drive", 1'b1, bus.ctl_drive_n)
    i_rst = 1'b0;
    req(1'b0, 1'b0, 18'h00010, 4'h0, 36'hd_12aa_5655);
    idle(1);
    drain();
    end_of_test();
  end
endmodule
`default_nettype wire
